// [nand_seq_pkg.sv]
// Constants for the two-plane flash command sequencer: register map, operations,
// step kinds, flash command bytes and pin timing counts.
// Assumes a 50 MHz reference clock and an asynchronous byte-wide flash bus.
package nand_seq_pkg;
	localparam int          REF_PERIOD_NS  = 20;
	localparam int          WE_LOW_NS      = 25;
	localparam int          WE_HIGH_NS     = 15;
	localparam int          RE_LOW_NS      = 25;
	localparam int          RE_HIGH_NS     = 15;
	localparam int          BUSY_ONSET_NS  = 100;
	localparam int          SYNC_STAGES    = 3;
	localparam logic [3:0] WE_LOW_CYC  = 4'((WE_LOW_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS);
	localparam logic [3:0] WE_HIGH_CYC = 4'((WE_HIGH_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS);
	localparam logic [3:0] RE_LOW_CYC  = 4'((RE_LOW_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS
		+ SYNC_STAGES);
	localparam logic [3:0] RE_HIGH_CYC = 4'((RE_HIGH_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS);
	localparam logic [3:0] ONSET_CYC   = 4'((BUSY_ONSET_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS);

	localparam logic [7:0] REG_CTRL     = 8'h00;
	localparam logic [7:0] REG_STATUS   = 8'h04;
	localparam logic [7:0] REG_A0_COL   = 8'h08;
	localparam logic [7:0] REG_A0_ROW   = 8'h0C;
	localparam logic [7:0] REG_A1_COL   = 8'h10;
	localparam logic [7:0] REG_A1_ROW   = 8'h14;
	localparam logic [7:0] REG_DATA     = 8'h18;
	localparam logic [7:0] REG_PL_STAT  = 8'h1C;

	localparam int CTRL_POLL_BIT = 4;
	localparam int CTRL_SEL_BIT  = 5;
	localparam int ST_ERR_BIT    = 1;
	localparam int ROW_PLANE_BIT = 6;
	localparam int ROW_DIE_BIT   = 18;
	localparam int FL_READY_BIT  = 6;
	localparam int FL_DONE_BIT   = 5;
	localparam int FL_FAIL_BIT   = 0;
	localparam int FL_PFAIL_BIT  = 1;

	localparam logic [3:0] OP_READ2     = 4'h0;
	localparam logic [3:0] OP_SELECT    = 4'h1;
	localparam logic [3:0] OP_RDBYTE    = 4'h2;
	localparam logic [3:0] OP_PROG_A    = 4'h3;
	localparam logic [3:0] OP_COLCHG    = 4'h4;
	localparam logic [3:0] OP_PROG_B    = 4'h5;
	localparam logic [3:0] OP_CONFIRM   = 4'h6;
	localparam logic [3:0] OP_CACHE     = 4'h7;
	localparam logic [3:0] OP_MOVE_RD   = 4'h8;
	localparam logic [3:0] OP_MOVE_PG   = 4'h9;
	localparam logic [3:0] OP_STATUS    = 4'hA;
	localparam logic [3:0] OP_WAITDONE  = 4'hB;
	localparam logic [3:0] OP_RESET     = 4'hC;
	localparam logic [3:0] OP_WRDATA    = 4'hD;

	localparam logic [3:0] K_END   = 4'h0;
	localparam logic [3:0] K_CMD   = 4'h1;
	localparam logic [3:0] K_A5_0  = 4'h2;
	localparam logic [3:0] K_A5_1  = 4'h3;
	localparam logic [3:0] K_A5_S  = 4'h4;
	localparam logic [3:0] K_COL_S = 4'h5;
	localparam logic [3:0] K_ROW_0 = 4'h6;
	localparam logic [3:0] K_ROW_1 = 4'h7;
	localparam logic [3:0] K_WAIT  = 4'h8;
	localparam logic [3:0] K_WAIT5 = 4'h9;
	localparam logic [3:0] K_RD    = 4'hA;
	localparam logic [3:0] K_RDST  = 4'hB;
	localparam logic [3:0] K_RDPL0 = 4'hC;
	localparam logic [3:0] K_RDPL1 = 4'hD;
	localparam logic [3:0] K_CHK   = 4'hE;
	localparam logic [3:0] K_WR    = 4'hF;

	localparam logic [7:0] C_READ      = 8'h00;
	localparam logic [7:0] C_READ_GO   = 8'h30;
	localparam logic [7:0] C_MOVE_GO   = 8'h35;
	localparam logic [7:0] C_SEL       = 8'h06;
	localparam logic [7:0] C_SEL_GO    = 8'hE0;
	localparam logic [7:0] C_PROG      = 8'h80;
	localparam logic [7:0] C_COLCHG    = 8'h85;
	localparam logic [7:0] C_DUMMY     = 8'h11;
	localparam logic [7:0] C_PROG_GO   = 8'h10;
	localparam logic [7:0] C_CACHE_GO  = 8'h15;
	localparam logic [7:0] C_STATUS    = 8'h70;
	localparam logic [7:0] C_PL_STATUS = 8'h78;
	localparam logic [7:0] C_RESET     = 8'hFF;

	typedef enum logic [3:0] {
		E_IDLE, E_STEP, E_SETUP, E_WE_LOW, E_WE_HIGH, E_RE_LOW, E_RE_HIGH, E_ONSET, E_BUSY
	} eng_state_type;
endpackage

// [nand_two_plane_command_sequencer.sv]
// Host-side sequencer that drives two-plane read, program, cache program and
// internal move command sequences onto a byte-wide asynchronous flash bus.
// Assumes software on a one-cycle register port and a flash busy line on rb_n.
`timescale 1ns/1ps
module nand_two_plane_command_sequencer (
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	input  wire logic        clk_en,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	output logic             nand_ce_n,
	output logic             nand_cle,
	output logic             nand_ale,
	output logic             nand_we_n,
	output logic             nand_re_n,
	output logic             nand_wp_n,
	output logic      [7:0]  io_out,
	output logic             io_oe,
	input  wire logic [7:0]  io_in,
	input  wire logic        rb_n
);
	function automatic logic [11:0] tail_f(input logic [4:0] i);
		unique case (i)
			5'd0:    tail_f = {nand_seq_pkg::K_WAIT, 8'h00};
			5'd1:    tail_f = {nand_seq_pkg::K_CMD, nand_seq_pkg::C_STATUS};
			5'd2:    tail_f = {nand_seq_pkg::K_RDST, 8'h00};
			5'd3:    tail_f = {nand_seq_pkg::K_CHK, 8'h00};
			5'd4:    tail_f = {nand_seq_pkg::K_CMD, nand_seq_pkg::C_PL_STATUS};
			5'd5:    tail_f = {nand_seq_pkg::K_ROW_0, 8'h00};
			5'd6:    tail_f = {nand_seq_pkg::K_RDPL0, 8'h00};
			5'd7:    tail_f = {nand_seq_pkg::K_CMD, nand_seq_pkg::C_PL_STATUS};
			5'd8:    tail_f = {nand_seq_pkg::K_ROW_1, 8'h00};
			5'd9:    tail_f = {nand_seq_pkg::K_RDPL1, 8'h00};
			default: tail_f = {nand_seq_pkg::K_END, 8'h00};
		endcase
	endfunction

	function automatic logic [11:0] pick_f(input logic [4:0] i, input logic [59:0] seq);
		if (i < 5'd5) begin
			pick_f = seq[12*(4-i) +: 12];
		end else begin
			pick_f = {nand_seq_pkg::K_END, 8'h00};
		end
	endfunction

	function automatic logic [11:0] step_f(input logic [3:0] op, input logic [4:0] i);
		logic [11:0] c00, c_sel, c_prog;
		c00    = {nand_seq_pkg::K_CMD, nand_seq_pkg::C_READ};
		c_sel  = {nand_seq_pkg::K_CMD, nand_seq_pkg::C_SEL};
		c_prog = {nand_seq_pkg::K_CMD, nand_seq_pkg::C_PROG};
		step_f = {nand_seq_pkg::K_END, 8'h00};
		unique case (op)
			nand_seq_pkg::OP_READ2, nand_seq_pkg::OP_MOVE_RD: begin
				if (i == 5'd5) begin
					step_f = {nand_seq_pkg::K_WAIT, 8'h00};
				end else begin
					step_f = pick_f(i, {c00, nand_seq_pkg::K_A5_0, 8'h00, c00,
						nand_seq_pkg::K_A5_1, 8'h00, nand_seq_pkg::K_CMD,
						(op == nand_seq_pkg::OP_READ2) ? nand_seq_pkg::C_READ_GO
						: nand_seq_pkg::C_MOVE_GO});
				end
			end
			nand_seq_pkg::OP_SELECT: step_f = pick_f(i, {c_sel, nand_seq_pkg::K_A5_S, 8'h00,
				nand_seq_pkg::K_CMD, nand_seq_pkg::C_SEL_GO, 24'h000000});
			nand_seq_pkg::OP_RDBYTE: step_f = pick_f(i, {nand_seq_pkg::K_RD, 8'h00, 48'h0});
			nand_seq_pkg::OP_PROG_A: step_f = pick_f(i, {c_prog, nand_seq_pkg::K_A5_0, 8'h00,
				36'h0});
			nand_seq_pkg::OP_COLCHG: step_f = pick_f(i, {nand_seq_pkg::K_CMD,
				nand_seq_pkg::C_COLCHG, nand_seq_pkg::K_COL_S, 8'h00, 36'h0});
			nand_seq_pkg::OP_PROG_B: step_f = pick_f(i, {nand_seq_pkg::K_CMD,
				nand_seq_pkg::C_DUMMY, nand_seq_pkg::K_WAIT, 8'h00, c_prog,
				nand_seq_pkg::K_A5_1, 8'h00, 12'h000});
			nand_seq_pkg::OP_CONFIRM, nand_seq_pkg::OP_CACHE: begin
				if (i == 5'd0) begin
					step_f = {nand_seq_pkg::K_CMD, (op == nand_seq_pkg::OP_CONFIRM)
						? nand_seq_pkg::C_PROG_GO : nand_seq_pkg::C_CACHE_GO};
				end else begin
					step_f = tail_f(i - 5'd1);
				end
			end
			nand_seq_pkg::OP_MOVE_PG: begin
				if (i < 5'd5) begin
					step_f = pick_f(i, {nand_seq_pkg::K_CMD, nand_seq_pkg::C_COLCHG,
						nand_seq_pkg::K_A5_0, 8'h00, nand_seq_pkg::K_CMD, nand_seq_pkg::C_DUMMY,
						nand_seq_pkg::K_WAIT, 8'h00, c_prog});
				end else if (i == 5'd5) begin
					step_f = {nand_seq_pkg::K_A5_1, 8'h00};
				end else if (i == 5'd6) begin
					step_f = {nand_seq_pkg::K_CMD, nand_seq_pkg::C_PROG_GO};
				end else begin
					step_f = tail_f(i - 5'd7);
				end
			end
			nand_seq_pkg::OP_STATUS: step_f = pick_f(i, {nand_seq_pkg::K_CMD,
				nand_seq_pkg::C_STATUS, nand_seq_pkg::K_RDST, 8'h00, 36'h0});
			nand_seq_pkg::OP_WAITDONE: step_f = pick_f(i, {nand_seq_pkg::K_WAIT5, 8'h00,
				48'h0});
			nand_seq_pkg::OP_RESET: step_f = pick_f(i, {nand_seq_pkg::K_CMD,
				nand_seq_pkg::C_RESET, nand_seq_pkg::K_WAIT, 8'h00, 36'h0});
			nand_seq_pkg::OP_WRDATA: step_f = pick_f(i, {nand_seq_pkg::K_WR, 8'h00, 48'h0});
			default: step_f = {nand_seq_pkg::K_END, 8'h00};
		endcase
	endfunction

	function automatic logic [7:0] addr_byte_f(input logic [15:0] col, input logic [23:0] row,
		input logic [2:0] n);
		unique case (n)
			3'd0:    addr_byte_f = col[7:0];
			3'd1:    addr_byte_f = {4'h0, col[11:8]};
			3'd2:    addr_byte_f = row[7:0];
			3'd3:    addr_byte_f = row[15:8];
			default: addr_byte_f = row[23:16];
		endcase
	endfunction

	function automatic logic pair_ok_f(input logic [23:0] r0, input logic [23:0] r1);
		pair_ok_f = (r0[nand_seq_pkg::ROW_PLANE_BIT] != r1[nand_seq_pkg::ROW_PLANE_BIT])
			&& (r0[nand_seq_pkg::ROW_DIE_BIT] == r1[nand_seq_pkg::ROW_DIE_BIT])
			&& (r0[5:0] == r1[5:0]);
	endfunction

	nand_seq_pkg::eng_state_type state_q;
	logic [3:0]  op_q, tmr_q, kind;
	logic [4:0]  idx_q;
	logic [2:0]  acnt_q, abase, alast;
	logic        poll_q, sel_q, pcmd_q, poll_now, multi_left;
	logic [7:0]  val, wbyte_q, rd_data_q, fstat_q, pl0_q, pl1_q, abyte, poll_bit_mask;
	logic [15:0] a0_col_q, a1_col_q, s_col;
	logic [23:0] a0_row_q, a1_row_q, s_row, last_row_q;
	logic [1:0]  phase_q;
	logic        need_sel_q, read_lock_q, last_valid_q, err_q;
	logic [2:0]  rb_s_q;
	logic [7:0]  io_s1_q, io_s2_q, io_s3_q;
	logic        rb_level_q;
	logic        start, refuse, accept, order_ok;
	logic [3:0]  new_op;

	assign {kind, val} = step_f(op_q, idx_q);
	assign s_col = sel_q ? a1_col_q : a0_col_q;
	assign s_row = sel_q ? a1_row_q : a0_row_q;
	assign poll_now = (kind == nand_seq_pkg::K_WAIT5) || (kind == nand_seq_pkg::K_WAIT && poll_q);
	assign poll_bit_mask = (kind == nand_seq_pkg::K_WAIT5) ? 8'h20 : 8'h40;
	assign nand_wp_n = 1'b1;

	// Start requests come from a control write or a data byte write.
	assign start  = reg_wr && (reg_addr == nand_seq_pkg::REG_CTRL
		|| reg_addr == nand_seq_pkg::REG_DATA);
	assign new_op = (reg_addr == nand_seq_pkg::REG_DATA) ? nand_seq_pkg::OP_WRDATA
		: reg_wdata[3:0];
	assign order_ok = !last_valid_q || (a0_row_q[23:6] != last_row_q[23:6])
		|| (a0_row_q[5:0] > last_row_q[5:0]);

	always_comb begin
		refuse = (state_q != nand_seq_pkg::E_IDLE) || (new_op > nand_seq_pkg::OP_WRDATA);
		unique case (new_op)
			nand_seq_pkg::OP_READ2: refuse = refuse || !pair_ok_f(a0_row_q, a1_row_q)
				|| (a0_col_q != a1_col_q);
			nand_seq_pkg::OP_MOVE_RD: refuse = refuse || !pair_ok_f(a0_row_q, a1_row_q);
			nand_seq_pkg::OP_PROG_A, nand_seq_pkg::OP_MOVE_PG: refuse = refuse || !order_ok
				|| !pair_ok_f(a0_row_q, a1_row_q) || (phase_q != 2'd0);
			nand_seq_pkg::OP_RDBYTE: refuse = refuse || need_sel_q;
			nand_seq_pkg::OP_COLCHG, nand_seq_pkg::OP_WRDATA:
				refuse = refuse || (phase_q == 2'd0);
			nand_seq_pkg::OP_PROG_B: refuse = refuse || (phase_q != 2'd1);
			nand_seq_pkg::OP_CONFIRM, nand_seq_pkg::OP_CACHE:
				refuse = refuse || (phase_q != 2'd2);
			default: refuse = refuse;
		endcase
	end
	assign accept = clk_en && start && !refuse;

	// Address cycle framing for the current step.
	always_comb begin
		abase = 3'd0;
		alast = 3'd0;
		abyte = val;
		unique case (kind)
			nand_seq_pkg::K_A5_0: begin alast = 3'd4; abyte = addr_byte_f(a0_col_q, a0_row_q, acnt_q); end
			nand_seq_pkg::K_A5_1: begin alast = 3'd4; abyte = addr_byte_f(a1_col_q, a1_row_q, acnt_q); end
			nand_seq_pkg::K_A5_S: begin alast = 3'd4; abyte = addr_byte_f(s_col, s_row, acnt_q); end
			nand_seq_pkg::K_COL_S: begin alast = 3'd1; abyte = addr_byte_f(s_col, s_row, acnt_q); end
			nand_seq_pkg::K_ROW_0: begin
				abase = 3'd2; alast = 3'd2;
				abyte = addr_byte_f(a0_col_q, a0_row_q, acnt_q + abase);
			end
			nand_seq_pkg::K_ROW_1: begin
				abase = 3'd2; alast = 3'd2;
				abyte = addr_byte_f(a1_col_q, a1_row_q, acnt_q + abase);
			end
			nand_seq_pkg::K_WR: abyte = wbyte_q;
			default: abyte = poll_now ? nand_seq_pkg::C_STATUS : val;
		endcase
	end
	assign multi_left = (acnt_q != alast);

	// Busy line and data bus synchronisers.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rb_s_q     <= 3'h0;
			rb_level_q <= 1'b0;
			io_s1_q    <= 8'h00;
			io_s2_q    <= 8'h00;
			io_s3_q    <= 8'h00;
		end else if (clk_en) begin
			rb_s_q  <= {rb_s_q[1:0], rb_n};
			io_s1_q <= io_in;
			io_s2_q <= io_s1_q;
			io_s3_q <= io_s2_q;
			if (rb_s_q[1] == rb_s_q[2]) begin
				rb_level_q <= rb_s_q[2];
			end
		end
	end

	// Software registers.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			a0_col_q  <= 16'h0000;
			a0_row_q  <= 24'h000000;
			a1_col_q  <= 16'h0000;
			a1_row_q  <= 24'h000040;
			reg_rdata <= 32'h00000000;
		end else if (clk_en) begin
			if (reg_wr && reg_addr == nand_seq_pkg::REG_A0_COL) a0_col_q <= reg_wdata[15:0];
			if (reg_wr && reg_addr == nand_seq_pkg::REG_A0_ROW) a0_row_q <= reg_wdata[23:0];
			if (reg_wr && reg_addr == nand_seq_pkg::REG_A1_COL) a1_col_q <= reg_wdata[15:0];
			if (reg_wr && reg_addr == nand_seq_pkg::REG_A1_ROW) a1_row_q <= reg_wdata[23:0];
			reg_rdata <= 32'h00000000;
			if (reg_rd) begin
				unique case (reg_addr)
					nand_seq_pkg::REG_CTRL: reg_rdata <= {26'h0, sel_q, poll_q, op_q};
					nand_seq_pkg::REG_STATUS: reg_rdata <= {16'h0, fstat_q, 1'b0, phase_q,
						rb_level_q, read_lock_q, need_sel_q, err_q,
						state_q != nand_seq_pkg::E_IDLE};
					nand_seq_pkg::REG_A0_COL: reg_rdata <= {16'h0, a0_col_q};
					nand_seq_pkg::REG_A0_ROW: reg_rdata <= {8'h0, a0_row_q};
					nand_seq_pkg::REG_A1_COL: reg_rdata <= {16'h0, a1_col_q};
					nand_seq_pkg::REG_A1_ROW: reg_rdata <= {8'h0, a1_row_q};
					nand_seq_pkg::REG_DATA: reg_rdata <= {24'h0, rd_data_q};
					nand_seq_pkg::REG_PL_STAT: reg_rdata <= {16'h0, pl1_q, pl0_q};
					default: reg_rdata <= 32'h00000000;
				endcase
			end
		end
	end

	// Sequence bookkeeping flags.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			phase_q      <= 2'd0;
			need_sel_q   <= 1'b0;
			read_lock_q  <= 1'b0;
			last_row_q   <= 24'h000000;
			last_valid_q <= 1'b0;
			err_q        <= 1'b0;
		end else if (clk_en) begin
			if (reg_wr && reg_addr == nand_seq_pkg::REG_STATUS && reg_wdata[nand_seq_pkg::ST_ERR_BIT]) begin
				err_q <= 1'b0;
			end
			if (start && refuse) begin
				err_q <= 1'b1;
			end
			if (accept) begin
				unique case (new_op)
					nand_seq_pkg::OP_READ2: begin
						read_lock_q <= 1'b1;
						need_sel_q  <= reg_wdata[nand_seq_pkg::CTRL_POLL_BIT];
					end
					nand_seq_pkg::OP_SELECT: need_sel_q <= 1'b0;
					nand_seq_pkg::OP_STATUS, nand_seq_pkg::OP_WAITDONE:
						need_sel_q <= need_sel_q || read_lock_q;
					nand_seq_pkg::OP_PROG_A, nand_seq_pkg::OP_MOVE_PG: begin
						read_lock_q  <= 1'b0;
						last_row_q   <= a0_row_q;
						last_valid_q <= 1'b1;
						phase_q      <= (new_op == nand_seq_pkg::OP_PROG_A) ? 2'd1 : 2'd0;
					end
					nand_seq_pkg::OP_PROG_B: phase_q <= 2'd2;
					nand_seq_pkg::OP_CONFIRM, nand_seq_pkg::OP_CACHE: phase_q <= 2'd0;
					nand_seq_pkg::OP_RESET: begin
						phase_q     <= 2'd0;
						need_sel_q  <= 1'b0;
						read_lock_q <= 1'b0;
					end
					default: phase_q <= phase_q;
				endcase
			end
		end
	end

	// Pin sequencing engine.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q   <= nand_seq_pkg::E_IDLE;
			op_q      <= 4'h0;
			idx_q     <= 5'd0;
			acnt_q    <= 3'd0;
			tmr_q     <= 4'h0;
			poll_q    <= 1'b0;
			sel_q     <= 1'b0;
			pcmd_q    <= 1'b0;
			wbyte_q   <= 8'h00;
			rd_data_q <= 8'h00;
			fstat_q   <= 8'h00;
			pl0_q     <= 8'h00;
			pl1_q     <= 8'h00;
			nand_ce_n <= 1'b1;
			nand_cle  <= 1'b0;
			nand_ale  <= 1'b0;
			nand_we_n <= 1'b1;
			nand_re_n <= 1'b1;
			io_out    <= 8'h00;
			io_oe     <= 1'b0;
		end else if (clk_en) begin
			unique case (state_q)
				nand_seq_pkg::E_IDLE: begin
					nand_ce_n <= 1'b1;
					if (accept) begin
						op_q      <= new_op;
						idx_q     <= 5'd0;
						acnt_q    <= 3'd0;
						pcmd_q    <= 1'b0;
						nand_ce_n <= 1'b0;
						state_q   <= nand_seq_pkg::E_STEP;
						if (new_op == nand_seq_pkg::OP_WRDATA) begin
							wbyte_q <= reg_wdata[7:0];
						end else begin
							poll_q <= reg_wdata[nand_seq_pkg::CTRL_POLL_BIT];
							sel_q  <= reg_wdata[nand_seq_pkg::CTRL_SEL_BIT];
						end
					end
				end
				nand_seq_pkg::E_STEP: begin
					nand_cle <= 1'b0;
					nand_ale <= 1'b0;
					io_oe    <= 1'b0;
					if (kind == nand_seq_pkg::K_END) begin
						state_q <= nand_seq_pkg::E_IDLE;
					end else if (kind == nand_seq_pkg::K_CHK) begin
						if (fstat_q[nand_seq_pkg::FL_FAIL_BIT] || fstat_q[nand_seq_pkg::FL_PFAIL_BIT]) begin
							idx_q <= idx_q + 5'd1;
						end else begin
							state_q <= nand_seq_pkg::E_IDLE;
						end
					end else if (poll_now && pcmd_q) begin
						tmr_q     <= nand_seq_pkg::RE_LOW_CYC - 4'd1;
						nand_re_n <= 1'b0;
						state_q   <= nand_seq_pkg::E_RE_LOW;
					end else if (kind == nand_seq_pkg::K_WAIT && !poll_q) begin
						tmr_q   <= nand_seq_pkg::ONSET_CYC - 4'd1;
						state_q <= nand_seq_pkg::E_ONSET;
					end else if (kind >= nand_seq_pkg::K_RD && kind <= nand_seq_pkg::K_RDPL1) begin
						tmr_q     <= nand_seq_pkg::RE_LOW_CYC - 4'd1;
						nand_re_n <= 1'b0;
						state_q   <= nand_seq_pkg::E_RE_LOW;
					end else begin
						nand_cle <= (kind == nand_seq_pkg::K_CMD) || poll_now;
						nand_ale <= (kind >= nand_seq_pkg::K_A5_0 && kind <= nand_seq_pkg::K_ROW_1);
						io_out   <= abyte;
						io_oe    <= 1'b1;
						state_q  <= nand_seq_pkg::E_SETUP;
					end
				end
				nand_seq_pkg::E_SETUP: begin
					nand_we_n <= 1'b0;
					tmr_q     <= nand_seq_pkg::WE_LOW_CYC - 4'd1;
					state_q   <= nand_seq_pkg::E_WE_LOW;
				end
				nand_seq_pkg::E_WE_LOW: begin
					if (tmr_q == 4'h0) begin
						nand_we_n <= 1'b1;
						tmr_q     <= nand_seq_pkg::WE_HIGH_CYC - 4'd1;
						state_q   <= nand_seq_pkg::E_WE_HIGH;
					end else begin
						tmr_q <= tmr_q - 4'h1;
					end
				end
				nand_seq_pkg::E_WE_HIGH: begin
					if (tmr_q == 4'h0) begin
						state_q <= nand_seq_pkg::E_STEP;
						if (poll_now) begin
							pcmd_q <= 1'b1;
						end else if (multi_left) begin
							acnt_q <= acnt_q + 3'd1;
						end else begin
							acnt_q <= 3'd0;
							idx_q  <= idx_q + 5'd1;
						end
					end else begin
						tmr_q <= tmr_q - 4'h1;
					end
				end
				nand_seq_pkg::E_RE_LOW: begin
					if (tmr_q != 4'h0) begin
						tmr_q <= tmr_q - 4'h1;
					end else if (io_s2_q == io_s3_q) begin
						nand_re_n <= 1'b1;
						tmr_q     <= nand_seq_pkg::RE_HIGH_CYC - 4'd1;
						state_q   <= nand_seq_pkg::E_RE_HIGH;
						unique case (kind)
							nand_seq_pkg::K_RD:    rd_data_q <= io_s3_q;
							nand_seq_pkg::K_RDPL0: pl0_q     <= io_s3_q;
							nand_seq_pkg::K_RDPL1: pl1_q     <= io_s3_q;
							default:               fstat_q   <= io_s3_q;
						endcase
					end
				end
				nand_seq_pkg::E_RE_HIGH: begin
					if (tmr_q == 4'h0) begin
						state_q <= nand_seq_pkg::E_STEP;
						if (poll_now) begin
							if ((fstat_q & poll_bit_mask) != 8'h00) begin
								pcmd_q <= 1'b0;
								idx_q  <= idx_q + 5'd1;
							end
						end else begin
							idx_q <= idx_q + 5'd1;
						end
					end else begin
						tmr_q <= tmr_q - 4'h1;
					end
				end
				nand_seq_pkg::E_ONSET: begin
					if (tmr_q == 4'h0) begin
						state_q <= nand_seq_pkg::E_BUSY;
					end else begin
						tmr_q <= tmr_q - 4'h1;
					end
				end
				nand_seq_pkg::E_BUSY: begin
					if (rb_level_q) begin
						idx_q   <= idx_q + 5'd1;
						state_q <= nand_seq_pkg::E_STEP;
					end
				end
			endcase
		end
	end
endmodule

// [nand_seq_monitor.sv]
// Checker of the flash pin framing driven by the sequencer.
// Assumes clk_en stays high, so every clock edge advances the engine.
`timescale 1ns/1ps
module nand_seq_monitor (
	input wire logic       ref_clk,
	input wire logic       rst_n,
	input wire logic       nand_ce_n,
	input wire logic       nand_cle,
	input wire logic       nand_ale,
	input wire logic       nand_we_n,
	input wire logic       nand_re_n,
	input wire logic       nand_wp_n,
	input wire logic [7:0] io_out,
	input wire logic       io_oe,
	input wire logic       rb_n
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	property p_latch; !(nand_cle && nand_ale); endproperty
	a_latch: assert property (p_latch) else $error("cle and ale high together");
	property p_we; $fell(nand_we_n) |-> ##1 !nand_we_n ##1 nand_we_n; endproperty
	a_we: assert property (p_we) else $error("write strobe width wrong");
	property p_ce; !nand_we_n || !nand_re_n |-> !nand_ce_n; endproperty
	a_ce: assert property (p_ce) else $error("strobe without chip enable");
	property p_hold; !nand_we_n |-> io_oe && $stable(io_out) && $stable(nand_cle); endproperty
	a_hold: assert property (p_hold) else $error("bus moved under write strobe");
	property p_re; !nand_re_n |-> !io_oe && !nand_cle && !nand_ale; endproperty
	a_re: assert property (p_re) else $error("bus driven during read");
	property p_re_len; $fell(nand_re_n) |-> !nand_re_n [*5]; endproperty
	a_re_len: assert property (p_re_len) else $error("read strobe too short");
	property p_wp; nand_wp_n; endproperty
	a_wp: assert property (p_wp) else $error("write protect asserted");
	property p_busy; nand_cle && $fell(nand_we_n) && !rb_n && !$past(rb_n, 2)
		|-> io_out inside {8'h70, 8'h78, 8'hFF}; endproperty
	a_busy: assert property (p_busy) else $error("illegal command while busy");
endmodule
bind nand_two_plane_command_sequencer nand_seq_monitor mon_u (.ref_clk(ref_clk), .rst_n(rst_n),
	.nand_ce_n(nand_ce_n), .nand_cle(nand_cle), .nand_ale(nand_ale), .nand_we_n(nand_we_n),
	.nand_re_n(nand_re_n), .nand_wp_n(nand_wp_n), .io_out(io_out), .io_oe(io_oe), .rb_n(rb_n));

// [nand_flash_model.sv]
// Behavioural two-plane flash die that answers the sequencer's pin cycles.
// Assumes one die; status reads return the same byte for both planes.
`timescale 1ns/1ps
module nand_flash_model #(
	parameter int BUSY_NS = 2000
) (
	input wire logic       ce_n,
	input wire logic       cle,
	input wire logic       ale,
	input wire logic       we_n,
	input wire logic       re_n,
	input wire logic [7:0] din,
	input wire logic       fail,
	output logic     [7:0] dout,
	output logic           rb_n
);
	logic [7:0] col_q = 8'h00;
	logic [7:0] last_q = 8'h00;
	logic [2:0] n_q = 3'h0;
	logic       plane_q = 1'b0;
	logic       stat_q = 1'b0;
	logic [7:0] rd_val;
	initial rb_n = 1'b1;
	always @(posedge we_n) begin
		if (!ce_n && cle) begin
			n_q <= 3'h0;
			stat_q <= din inside {8'h70, 8'h78};
			if (din inside {8'h30, 8'h35, 8'h11, 8'h10, 8'h15, 8'hFF}) begin
				rb_n <= 1'b0;
				rb_n <= #(din == 8'h11 ? BUSY_NS / 4 : BUSY_NS) 1'b1;
			end
			if (din == 8'h30) plane_q <= 1'b0;
		end else if (!ce_n && ale) begin
			n_q <= n_q + 3'h1;
			if (n_q == 3'h0) col_q <= din;
			if (n_q == 3'h2) plane_q <= din[6];
		end
	end
	always @(posedge re_n) begin
		last_q <= rd_val;
		if (!stat_q) col_q <= col_q + 8'h01;
	end
	assign rd_val = stat_q ? {1'b1, rb_n, rb_n, 3'h0, fail, fail}
		: col_q ^ {plane_q, 7'h00};
	assign dout = (!ce_n && !re_n) ? rd_val : ~last_q;
endmodule

// [test_nand_two_plane_command_sequencer.sv]
// Self-checking bench for the two-plane command sequencer.
// Assumes the flash model on the pins and clk_en held high except during the frozen write check.
`timescale 1ns/1ps
module test_nand_two_plane_command_sequencer;
	typedef struct packed {logic [23:0] row; logic [15:0] col; logic err;} case_type;
	logic ref_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, fail = 1'b0, clk_en = 1'b1;
	logic [7:0] reg_addr = 8'h00, io_out, io_in;
	logic [31:0] reg_wdata = 32'h0, reg_rdata, s;
	logic nand_ce_n, nand_cle, nand_ale, nand_we_n, nand_re_n, io_oe, rb_n;
	int n_fail = 0, tests_run = 0;
	case_type tbl [5] = '{{24'h000005, 16'h0010, 1'b1}, {24'h040045, 16'h0010, 1'b1},
		{24'h000046, 16'h0010, 1'b1}, {24'h000045, 16'h0011, 1'b1}, {24'h000045, 16'h0010, 1'b0}};
	nand_two_plane_command_sequencer dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .nand_ce_n(nand_ce_n), .nand_cle(nand_cle), .nand_ale(nand_ale),
		.nand_we_n(nand_we_n), .nand_re_n(nand_re_n), .nand_wp_n(), .io_out(io_out),
		.io_oe(io_oe), .io_in(io_in), .rb_n(rb_n));
	nand_flash_model #(.BUSY_NS(2000)) flash_u (.ce_n(nand_ce_n), .cle(nand_cle), .ale(nand_ale),
		.we_n(nand_we_n), .re_n(nand_re_n), .din(io_out), .fail(fail), .dout(io_in), .rb_n(rb_n));
	initial forever #10 ref_clk = ~ref_clk;
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk) begin reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1; end
		@(posedge ref_clk) reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge ref_clk) begin reg_addr <= a; reg_rd <= 1'b1; end
		@(posedge ref_clk) reg_rd <= 1'b0;
		#1 s = reg_rdata;
	endtask
	task automatic op(input logic [7:0] a, input logic [31:0] d);
		wr(a, d);
		for (int i = 0; i < 400; i++) begin
			rd(8'h04);
			if (s[0] === 1'b0) break;
		end
	endtask
	task automatic tally_and_finish;
		$display("Checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		#1500000;
		n_fail++;
		tally_and_finish();
	end
	initial begin
		repeat (20) @(posedge ref_clk);
		rst_n <= 1'b1;
		wr(8'h08, 32'h10);
		wr(8'h0C, 32'h5);
		foreach (tbl[i]) begin
			wr(8'h10, 32'(tbl[i].col));
			wr(8'h14, 32'(tbl[i].row));
			op(8'h00, 32'h0);
			rd(8'h04);
			chk("refusal", 32'(tbl[i].err), 32'(s[1]));
			wr(8'h04, 32'h2);
		end
		op(8'h00, 32'h2);
		rd(8'h18);
		chk("plane0 first", 32'h10, s);
		op(8'h00, 32'h2);
		rd(8'h18);
		chk("plane0 next", 32'h11, s);
		op(8'h00, 32'h21);
		op(8'h00, 32'h2);
		rd(8'h18);
		chk("plane1 first", 32'h90, s);
		op(8'h00, 32'h10);
		op(8'h00, 32'h2);
		rd(8'h04);
		chk("select first", 32'h1, 32'(s[1]));
		wr(8'h04, 32'h2);
		op(8'h00, 32'h1);
		op(8'h00, 32'h2);
		rd(8'h18);
		chk("plane0 after select", 32'h10, s);
		op(8'h00, 32'h3);
		op(8'h18, 32'hA5);
		op(8'h00, 32'h4);
		op(8'h00, 32'h5);
		op(8'h18, 32'h5A);
		op(8'h00, 32'h16);
		rd(8'h04);
		chk("program err", 32'h0, 32'(s[1]));
		op(8'h00, 32'h3);
		rd(8'h04);
		chk("page order", 32'h1, 32'(s[1]));
		wr(8'h04, 32'h2);
		wr(8'h0C, 32'h6);
		wr(8'h14, 32'h46);
		fail <= 1'b1;
		op(8'h00, 32'h3);
		op(8'h18, 32'h11);
		op(8'h00, 32'h5);
		op(8'h18, 32'h22);
		op(8'h00, 32'h7);
		rd(8'h1C);
		chk("plane status", 32'hE3E3, s);
		op(8'h00, 32'hB);
		rd(8'h04);
		chk("final status", 32'hE3, 32'(s[15:8]));
		rd(8'hFC);
		chk("unmapped", 32'h0, s);
		@(posedge ref_clk) clk_en <= 1'b0;
		wr(8'h10, 32'h77);
		@(posedge ref_clk) clk_en <= 1'b1;
		rd(8'h10);
		chk("frozen write", 32'h10, s);
		@(posedge ref_clk) rst_n <= 1'b0;
		repeat (3) @(posedge ref_clk);
		rst_n <= 1'b1;
		rd(8'h14);
		chk("second row reset", 32'h40, s);
		tally_and_finish();
	end
endmodule
